//--- ccs_clk_src.sv
// Purpose: Far-side clock sources feeding the clocking block
// Assumes: Sources are slow against the system clock
// Notes: All levels come from one free-running counter
`timescale 1ns/100ps
`default_nettype none
module ccs_clk_src (
    input wire logic clk,
    output var logic diff_clk,
    output var logic single_ended_ref_in,
    output var logic serdes_clk,
    output var logic tstamp,
    output var logic sysref
);
    // ----------------------------------------
    // Source levels
    // ----------------------------------------
    logic [6:0] cnt_q = 7'h00;
    always_ff @(posedge clk) begin
        cnt_q <= cnt_q + 7'h01;
    end
    assign diff_clk = cnt_q[2];
    // Only relied on as a reference with the PLL strap high
    assign single_ended_ref_in = cnt_q[3];
    assign serdes_clk = cnt_q[1];
    assign tstamp = cnt_q[5];
    assign sysref = cnt_q[6];
endmodule
`default_nettype wire

//--- ccs_clocking.sv
// Purpose: Clock selection, PLL sequencing and clock outputs of a converter
// Assumes: Clock pins are slow enough to be sampled at 100 MHz
// Notes: Avalon-MM slave, one wait cycle per access
`timescale 1ns/100ps
`default_nettype none
module ccs_clocking
    import ccs_pkg::*;
(
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic [4:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output var logic [31:0] AVS_READDATA,
    output var logic AVS_WAITREQUEST,
    input wire logic PLL_ENABLE_STRAP,
    input wire logic REF_SELECT_STRAP,
    input wire logic [1:0] CLOCK_OUT_CONFIG_STRAPS,
    input wire logic POWER_DOWN_PIN,
    input wire logic DIFF_CLK_IN,
    input wire logic SINGLE_ENDED_REF_IN,
    input wire logic SYSREF_IN,
    input wire logic TIMESTAMP_IN,
    input wire logic SERDES_PLL_CLK_IN,
    input wire logic OVERRANGE_C_IN,
    input wire logic OVERRANGE_D_IN,
    output var logic SAMPLE_CLK_OUT,
    output var logic REF_REPEAT_OUT,
    output var logic TRIGGER_CLOCK_OUT,
    output var logic CHAN_C_FLAG_PIN,
    output var logic CHAN_D_FLAG_PIN,
    output var logic SYSREF_CAPTURED
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [10:0] pins_s;
    logic pll_en_s, ref_sel_s, pd_s, diff_s, se_s, sysref_s, tstamp_s, spll_s;
    logic [1:0] straps_s;

    ccs_sync2 #(.W(10)) u_sync (
        .clk(CLOCK),
        .srst(SRST),
        .din({PLL_ENABLE_STRAP, REF_SELECT_STRAP, CLOCK_OUT_CONFIG_STRAPS,
              POWER_DOWN_PIN, DIFF_CLK_IN, SINGLE_ENDED_REF_IN, SYSREF_IN,
              TIMESTAMP_IN, SERDES_PLL_CLK_IN}),
        .dout(pins_s[9:0])
    );
    assign pins_s[10] = 1'b0;
    assign {pll_en_s, ref_sel_s, straps_s, pd_s, diff_s, se_s, sysref_s,
            tstamp_s, spll_s} = pins_s[9:0];

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    logic [15:0] pll_ctrl_q, pll_ctrl_d, div_q, div_d, trig_q, trig_d;
    logic [15:0] clkout_q, clkout_d, srsel_q, srsel_d;
    logic [31:0] rdata_d;
    logic wait_d;
    logic [15:0] status;
    logic [7:0] srpos_q;
    logic req, wr_go;

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [1:0] be,
                                          input logic [15:0] mask);
        logic [15:0] v;
        v = old;
        if (be[0]) v[7:0] = wd[7:0];
        if (be[1]) v[15:8] = wd[15:8];
        return v & mask;
    endfunction

    assign req = AVS_READ || AVS_WRITE;
    // A write lands on the edge where the master sees waitrequest low
    assign wr_go = AVS_WRITE && !AVS_WAITREQUEST;

    always_comb begin
        wait_d = !(req && AVS_WAITREQUEST);
        rdata_d = AVS_READDATA;
        pll_ctrl_d = pll_ctrl_q;
        div_d = div_q;
        trig_d = trig_q;
        clkout_d = clkout_q;
        srsel_d = srsel_q;
        if (AVS_READ && AVS_WAITREQUEST) begin
            if (AVS_ADDRESS == ADDR_PLL_CTRL) begin
                rdata_d = {16'h0000, pll_ctrl_q};
            end else if (AVS_ADDRESS == ADDR_DIVIDERS) begin
                rdata_d = {16'h0000, div_q};
            end else if (AVS_ADDRESS == ADDR_STATUS) begin
                rdata_d = {16'h0000, status};
            end else if (AVS_ADDRESS == ADDR_TRIG_CTRL) begin
                rdata_d = {16'h0000, trig_q};
            end else if (AVS_ADDRESS == ADDR_CLKOUT_CTRL) begin
                rdata_d = {16'h0000, clkout_q};
            end else if (AVS_ADDRESS == ADDR_SYSREF_CTRL) begin
                rdata_d = {16'h0000, srsel_q};
            end else begin
                rdata_d = 32'h00000000;
            end
        end
        if (wr_go) begin
            if (AVS_ADDRESS == ADDR_PLL_CTRL) begin
                pll_ctrl_d = merge(pll_ctrl_q, AVS_WRITEDATA[15:0], AVS_BYTEENABLE[1:0],
                                   PLL_CTRL_MASK);
            end else if (AVS_ADDRESS == ADDR_DIVIDERS) begin
                // Dividers should only change under PLL reset
                div_d = merge(div_q, AVS_WRITEDATA[15:0], AVS_BYTEENABLE[1:0],
                              DIVIDERS_MASK);
            end else if (AVS_ADDRESS == ADDR_TRIG_CTRL) begin
                trig_d = merge(trig_q, AVS_WRITEDATA[15:0], AVS_BYTEENABLE[1:0],
                               TRIG_CTRL_MASK);
            end else if (AVS_ADDRESS == ADDR_CLKOUT_CTRL) begin
                clkout_d = merge(clkout_q, AVS_WRITEDATA[15:0], AVS_BYTEENABLE[1:0],
                                 CLKOUT_CTRL_MASK);
            end else if (AVS_ADDRESS == ADDR_SYSREF_CTRL) begin
                srsel_d = merge(srsel_q, AVS_WRITEDATA[15:0], AVS_BYTEENABLE[1:0],
                                SYSREF_CTRL_MASK);
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA <= 32'h00000000;
            pll_ctrl_q <= PLL_CTRL_RST;
            div_q <= DIVIDERS_RST;
            trig_q <= TRIG_CTRL_RST;
            clkout_q <= CLKOUT_CTRL_RST;
            srsel_q <= SYSREF_CTRL_RST;
        end else begin
            AVS_WAITREQUEST <= wait_d;
            AVS_READDATA <= rdata_d;
            pll_ctrl_q <= pll_ctrl_d;
            div_q <= div_d;
            trig_q <= trig_d;
            clkout_q <= clkout_d;
            srsel_q <= srsel_d;
        end
    end

    // ----------------------------------------
    // Converter PLL sequencer
    // ----------------------------------------
    ccs_pll_state_type state_q, state_d;
    logic [7:0] cnt_q, cnt_d;
    logic cal_done_q, cal_done_d;
    logic [7:0] pv;
    logic div_ok, pll_rst;

    assign pll_rst = pll_ctrl_q[PLL_RESET_BIT];
    assign pv = 8'(div_q[P_LSB +: 4] * div_q[V_LSB +: 4]);
    assign div_ok = (pv == 8'h05) || (pv == 8'h06) || (pv == 8'h08) ||
                    (pv == 8'h0A) || (pv == 8'h0C);

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        cal_done_d = cal_done_q;
        case (state_q)
            ST_RESET: begin
                cnt_d = 8'h00;
                if (!pll_rst && pll_en_s) begin
                    state_d = pll_ctrl_q[CAL_EN_BIT] ? ST_CAL : ST_SETTLE;
                end
            end
            ST_CAL: begin
                cnt_d = cnt_q + 8'h01;
                if (cnt_q == 8'(CAL_CYCLES - 1)) begin
                    cnt_d = 8'h00;
                    cal_done_d = 1'b1;
                    state_d = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                // An unsupported divisor never locks
                if (div_ok) begin
                    cnt_d = cnt_q + 8'h01;
                    if (cnt_q == 8'(LOCK_CYCLES - 1)) begin
                        state_d = ST_LOCKED;
                    end
                end
            end
            default: begin
                state_d = ST_LOCKED;
            end
        endcase
        if (pll_rst || !pll_en_s) begin
            state_d = ST_RESET;
            cal_done_d = 1'b0;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            state_q <= ST_RESET;
            cnt_q <= 8'h00;
            cal_done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            cal_done_q <= cal_done_d;
        end
    end

    assign status = {srpos_q, 4'h0, pll_en_s, div_ok, (state_q == ST_LOCKED) && !pll_rst,
                     cal_done_q && !pll_rst};

    // ----------------------------------------
    // Clock selection and dividers
    // ----------------------------------------
    logic ref_s, ref_prev_q, ref_rise, spll_prev_q, spll_rise;
    logic vco_div, ref_div2, ref_div4, trig_div;

    // Direct mode always takes the differential input
    assign ref_s = (pll_en_s && ref_sel_s) ? se_s : diff_s;
    assign ref_rise = ref_s && !ref_prev_q;
    assign spll_rise = spll_s && !spll_prev_q;

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            ref_prev_q <= 1'b0;
            spll_prev_q <= 1'b0;
        end else begin
            ref_prev_q <= ref_s;
            spll_prev_q <= spll_s;
        end
    end

    // VCO stand-in: system clock divided by twice V times P
    ccs_toggle_div #(.W(8)) u_vco (
        .clk(CLOCK), .srst(SRST), .tick(state_q == ST_LOCKED),
        .half(pv), .out_q(vco_div)
    );
    ccs_toggle_div #(.W(8)) u_div2 (
        .clk(CLOCK), .srst(SRST), .tick(ref_rise),
        .half(8'h01), .out_q(ref_div2)
    );
    ccs_toggle_div #(.W(8)) u_div4 (
        .clk(CLOCK), .srst(SRST), .tick(ref_rise),
        .half(8'h02), .out_q(ref_div4)
    );
    ccs_toggle_div #(.W(8)) u_trig (
        .clk(CLOCK), .srst(SRST), .tick(spll_rise),
        .half(trig_q[RX_DIV_LSB +: 8]), .out_q(trig_div)
    );

    // ----------------------------------------
    // Output pins
    // ----------------------------------------
    logic [1:0] c_mode, d_mode;
    logic overrange_enable, strap_ovr;
    logic samp_d, refo_d, trig_d_out, pin_c_d, pin_d_d;

    assign overrange_enable = clkout_q[OVERRANGE_ENABLE_BIT];
    assign strap_ovr = clkout_q[STRAP_OVR_BIT];

    always_comb begin
        if (strap_ovr) begin
            c_mode = clkout_q[C_MODE_LSB +: 2];
            d_mode = (c_mode != 2'h0) ? clkout_q[D_MODE_LSB +: 2] : 2'h0;
        end else begin
            c_mode = straps_s;
            d_mode = (straps_s != 2'h0) ? 2'h1 : 2'h0;
        end
        // Sampling clock feeds core, logic and serializer PLL
        samp_d = pll_en_s ? vco_div : diff_s;
        refo_d = pll_en_s && pll_ctrl_q[REFO_EN_BIT] && ref_s;
        if (trig_q[TRIG_MODE_LSB +: 2] == TRIG_MODE_TSTAMP) begin
            trig_d_out = tstamp_s;
        end else begin
            trig_d_out = trig_div;
        end
        trig_d_out = trig_d_out && trig_q[TRIG_EN_BIT];
        // Clock modes take the pin before over-range
        case (c_mode)
            2'h1: pin_c_d = ref_s;
            2'h2: pin_c_d = ref_div2;
            2'h3: pin_c_d = ref_div4;
            default: pin_c_d = overrange_enable && OVERRANGE_C_IN;
        endcase
        case (d_mode)
            2'h1: pin_d_d = ref_s;
            2'h2: pin_d_d = ref_div2;
            2'h3: pin_d_d = ref_div4;
            default: pin_d_d = overrange_enable && OVERRANGE_D_IN;
        endcase
        if (pd_s) begin
            refo_d = 1'b0;
            trig_d_out = 1'b0;
            if (c_mode != 2'h0) pin_c_d = 1'b0;
            if (d_mode != 2'h0) pin_d_d = 1'b0;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            SAMPLE_CLK_OUT <= 1'b0;
            REF_REPEAT_OUT <= 1'b0;
            TRIGGER_CLOCK_OUT <= 1'b0;
            CHAN_C_FLAG_PIN <= 1'b0;
            CHAN_D_FLAG_PIN <= 1'b0;
        end else begin
            SAMPLE_CLK_OUT <= samp_d;
            REF_REPEAT_OUT <= refo_d;
            TRIGGER_CLOCK_OUT <= trig_d_out;
            CHAN_C_FLAG_PIN <= pin_c_d;
            CHAN_D_FLAG_PIN <= pin_d_d;
        end
    end

    // ----------------------------------------
    // SYSREF window and capture
    // ----------------------------------------
    logic [7:0] hist_q, hist_d, srpos_d;
    logic cap_d;

    always_comb begin
        hist_d = {hist_q[6:0], sysref_s};
        srpos_d = srpos_q;
        cap_d = SYSREF_CAPTURED;
        if (ref_rise) begin
            // Set bit marks a tap next to a SYSREF edge
            srpos_d = hist_q ^ {hist_q[6:0], sysref_s};
            cap_d = hist_q[srsel_q[SYSREF_SEL_LSB +: 3]];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            hist_q <= 8'h00;
            srpos_q <= 8'h00;
            SYSREF_CAPTURED <= 1'b0;
        end else begin
            hist_q <= hist_d;
            srpos_q <= srpos_d;
            SYSREF_CAPTURED <= cap_d;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_release;
        $fell(pll_rst) && pll_ctrl_q[CAL_EN_BIT] && pll_en_s && state_q == ST_RESET;
    endsequence
    property p_cal_start;
        @(posedge CLOCK) disable iff (SRST)
        s_release |=> state_q == ST_CAL;
    endproperty
    a_cal_start: assert property (p_cal_start) else $error("cal did not start");
    property p_cal_done;
        @(posedge CLOCK) disable iff (SRST)
        $rose(state_q == ST_CAL) |-> ##[1:110] (cal_done_q || pll_rst || !pll_en_s);
    endproperty
    a_cal_done: assert property (p_cal_done) else $error("cal never done");
    property p_flags_zero;
        @(posedge CLOCK) disable iff (SRST)
        pll_rst |-> status[1:0] == 2'b00;
    endproperty
    a_flags_zero: assert property (p_flags_zero) else $error("flag set in reset");
    property p_lock_ok;
        @(posedge CLOCK) disable iff (SRST)
        $rose(state_q == ST_LOCKED) |-> div_ok && $past(state_q) == ST_SETTLE;
    endproperty
    a_lock_ok: assert property (p_lock_ok) else $error("bad lock");
    property p_pd_stop;
        @(posedge CLOCK) disable iff (SRST)
        pd_s |=> !REF_REPEAT_OUT && !TRIGGER_CLOCK_OUT;
    endproperty
    a_pd_stop: assert property (p_pd_stop) else $error("output during pd");
    property p_refo;
        @(posedge CLOCK) disable iff (SRST)
        pll_en_s && pll_ctrl_q[REFO_EN_BIT] && !pd_s |=> REF_REPEAT_OUT == $past(ref_s);
    endproperty
    a_refo: assert property (p_refo) else $error("ref repeat wrong");
    property p_trig_off;
        @(posedge CLOCK) disable iff (SRST)
        !trig_q[TRIG_EN_BIT] |=> !TRIGGER_CLOCK_OUT;
    endproperty
    a_trig_off: assert property (p_trig_off) else $error("trigger not off");
    property p_c_ref;
        @(posedge CLOCK) disable iff (SRST)
        c_mode == 2'h1 && !pd_s |=> CHAN_C_FLAG_PIN == $past(ref_s);
    endproperty
    a_c_ref: assert property (p_c_ref) else $error("chan c not ref");
    property p_d_needs_c;
        @(posedge CLOCK) disable iff (SRST)
        strap_ovr && clkout_q[1:0] == 2'h0 && !overrange_enable |=> !CHAN_D_FLAG_PIN;
    endproperty
    a_d_needs_c: assert property (p_d_needs_c) else $error("chan d alone");
    property p_direct;
        @(posedge CLOCK) disable iff (SRST)
        !pll_en_s |=> SAMPLE_CLK_OUT == $past(diff_s);
    endproperty
    a_direct: assert property (p_direct) else $error("direct clock wrong");
endmodule
`default_nettype wire

//--- ccs_pkg.sv
// Purpose: Shared constants and types of the converter clocking block
// Assumes: Register offsets are byte addresses of aligned 32-bit words
// Notes: Only the low 16 bits of each register are used
package ccs_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [4:0] ADDR_PLL_CTRL = 5'h00;
    localparam logic [4:0] ADDR_DIVIDERS = 5'h04;
    localparam logic [4:0] ADDR_STATUS = 5'h08;
    localparam logic [4:0] ADDR_TRIG_CTRL = 5'h0C;
    localparam logic [4:0] ADDR_CLKOUT_CTRL = 5'h10;
    localparam logic [4:0] ADDR_SYSREF_CTRL = 5'h14;
    // Writable bits and reset values
    localparam logic [15:0] PLL_CTRL_MASK = 16'h0007;
    localparam logic [15:0] PLL_CTRL_RST = 16'h0005;
    localparam logic [15:0] DIVIDERS_MASK = 16'hFFFF;
    localparam logic [15:0] DIVIDERS_RST = 16'h1051;
    localparam logic [15:0] TRIG_CTRL_MASK = 16'hFF07;
    localparam logic [15:0] TRIG_CTRL_RST = 16'h0400;
    localparam logic [15:0] CLKOUT_CTRL_MASK = 16'h003F;
    localparam logic [15:0] CLKOUT_CTRL_RST = 16'h0000;
    localparam logic [15:0] SYSREF_CTRL_MASK = 16'h0007;
    localparam logic [15:0] SYSREF_CTRL_RST = 16'h0000;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int PLL_RESET_BIT = 0;
    localparam int CAL_EN_BIT = 1;
    localparam int REFO_EN_BIT = 2;
    localparam int P_LSB = 0;
    localparam int V_LSB = 4;
    localparam int N_LSB = 8;
    localparam int STAT_CAL_DONE_BIT = 0;
    localparam int STAT_LOCK_BIT = 1;
    localparam int STAT_DIV_OK_BIT = 2;
    localparam int STAT_PLL_MODE_BIT = 3;
    localparam int STAT_POS_LSB = 8;
    localparam int TRIG_EN_BIT = 0;
    localparam int TRIG_MODE_LSB = 1;
    localparam int RX_DIV_LSB = 8;
    localparam int C_MODE_LSB = 0;
    localparam int D_MODE_LSB = 2;
    localparam int STRAP_OVR_BIT = 4;
    localparam int OVERRANGE_ENABLE_BIT = 5;
    localparam int SYSREF_SEL_LSB = 0;
    localparam logic [1:0] TRIG_MODE_TSTAMP = 2'h3;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int CAL_TIME_NS = 1000;
    localparam int LOCK_TIME_NS = 500;
    localparam int CAL_CYCLES = (CAL_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int LOCK_CYCLES = (LOCK_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    // Gray along reset, calibrate, settle, locked
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_CAL = 2'b01,
        ST_SETTLE = 2'b11,
        ST_LOCKED = 2'b10
    } ccs_pll_state_type;
endpackage

//--- ccs_sync2.sv
// Purpose: Two-stage synchroniser for pin levels
// Assumes: Inputs are asynchronous levels
// Notes: Only the second stage may be read
`timescale 1ns/100ps
`default_nettype none
module ccs_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [W-1:0] din,
    output var logic [W-1:0] dout
);
    logic [W-1:0] meta_q;

    initial begin
        if (W < 1) $error("ccs_sync2 width below one");
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            meta_q <= '0;
            dout <= '0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule
`default_nettype wire

//--- ccs_toggle_div.sv
// Purpose: Toggles its output every 'half' ticks
// Assumes: Tick is a level on the same clock; each cycle it is high counts once
// Notes: A half of zero acts as one
`timescale 1ns/100ps
`default_nettype none
module ccs_toggle_div #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic tick,
    input wire logic [W-1:0] half,
    output var logic out_q
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic out_d;

    initial begin
        if (W < 1) $error("ccs_toggle_div width below one");
    end

    always_comb begin
        cnt_d = cnt_q;
        out_d = out_q;
        if (tick) begin
            if (cnt_q + W'(1) >= half) begin
                cnt_d = '0;
                out_d = !out_q;
            end else begin
                cnt_d = cnt_q + W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q <= '0;
            out_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            out_q <= out_d;
        end
    end
endmodule
`default_nettype wire

//--- tb_top.sv
// Purpose: Register and pin checks of the converter clocking block
// Assumes: Bus waits on waitrequest; pins reach outputs three edges late
// Notes: Pin checks compare against delayed copies of the sources
`timescale 1ns/100ps
`default_nettype none
module tb_top import ccs_pkg::*; ;
    logic clk = 1'h0;
    logic srst = 1'h1;
    logic rd = 1'h0;
    logic wr = 1'h0;
    logic pll_s = 1'h0;
    logic ref_s = 1'h0;
    logic pwd = 1'h0;
    logic chan_c_flag_pin = 1'h0;
    logic chan_d_flag_pin = 1'h0;
    logic [1:0] cfg = 2'h0;
    logic [3:0] be = 4'h3;
    logic [4:0] adr = 5'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, q;
    logic wait_r, smp, refo, trig, pc, pdd, syscap, diff, se, sdes, tst, sref;
    logic [2:0] dh = 3'h0, sh = 3'h0, th = 3'h0;
    int fail_count = 0;
    int n_checks = 0;
    wire [5:0] outv = {syscap, pdd, pc, trig, refo, smp};
    wire [4:0] srcv = {1'h1, th[2], sh[2], dh[2], 1'h0};

    initial begin
        forever #5 clk = ~clk;
    end

    ccs_clk_src src_u (.clk(clk), .diff_clk(diff), .single_ended_ref_in(se), .serdes_clk(sdes),
        .tstamp(tst), .sysref(sref));

    ccs_clocking dut_u (.CLOCK(clk), .SRST(srst), .AVS_ADDRESS(adr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be),
        .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_r), .PLL_ENABLE_STRAP(pll_s),
        .REF_SELECT_STRAP(ref_s), .CLOCK_OUT_CONFIG_STRAPS(cfg), .POWER_DOWN_PIN(pwd),
        .DIFF_CLK_IN(diff), .SINGLE_ENDED_REF_IN(se), .SYSREF_IN(sref),
        .TIMESTAMP_IN(tst), .SERDES_PLL_CLK_IN(sdes), .OVERRANGE_C_IN(chan_c_flag_pin),
        .OVERRANGE_D_IN(chan_d_flag_pin), .SAMPLE_CLK_OUT(smp), .REF_REPEAT_OUT(refo),
        .TRIGGER_CLOCK_OUT(trig), .CHAN_C_FLAG_PIN(pc), .CHAN_D_FLAG_PIN(pdd),
        .SYSREF_CAPTURED(syscap));

    // Source history, aligned to the sync-plus-register latency
    always @(posedge clk) begin
        dh <= {dh[1:0], diff};
        sh <= {sh[1:0], se};
        th <= {th[1:0], tst};
    end

    task automatic conclude;
        $display("checks %0d failures %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk_reg(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask

    // Output o must follow source s for 40 cycles, after a five-cycle settle
    task automatic chk_pin(input string nm, input int o, input int s);
        int i;
        repeat (5) @(posedge clk);
        for (i = 0; i < 40; i++) begin
            @(posedge clk);
            n_checks++;
            if (outv[o] !== srcv[s]) begin
                $display("CHECK FAILED %s expected %b seen %b", nm, srcv[s], outv[o]);
                fail_count++;
            end
        end
    endtask

    // Half period of output o in cycles; a missing edge counts as zero
    task automatic chk_half(input string nm, input int o, input logic [15:0] e);
        int i;
        logic v;
        logic [15:0] n;
        n = 16'h0000;
        repeat (8) @(posedge clk);
        v = outv[o];
        for (i = 0; i < 200 && outv[o] === v; i++) @(posedge clk);
        v = outv[o];
        for (i = 0; i < 200 && n == 16'h0000; i++) begin
            @(posedge clk);
            if (outv[o] !== v) n = 16'(i + 1);
        end
        chk_reg(nm, e, n);
    endtask

    task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d,
        output logic [31:0] r);
        int i;
        @(posedge clk);
        rd <= ~w;
        wr <= w;
        adr <= a;
        wdat <= {16'h0, d};
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (wait_r === 1'h0) break;
        end
        r = rdat;
        rd <= 1'h0;
        wr <= 1'h0;
        if (i == 50) begin
            fail_count++;
            conclude();
        end
    endtask

    task automatic wreg(input logic [4:0] a, input logic [15:0] d);
        bus(1'h1, a, d, q);
    endtask

    task automatic rexp(input logic [4:0] a, input logic [15:0] e, input logic [15:0] m);
        bus(1'h0, a, 16'h0, q);
        chk_reg($sformatf("reg %h", a), e, q[15:0] & m);
    endtask

    task automatic poll(input logic [15:0] m);
        int i;
        for (i = 0; i < 200; i++) begin
            bus(1'h0, ADDR_STATUS, 16'h0, q);
            if ((q[15:0] & m) === m) break;
        end
        chk_reg("status poll", m, q[15:0] & m);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'h0;
        rexp(ADDR_PLL_CTRL, 16'h0005, 16'hFFFF);
        rexp(ADDR_DIVIDERS, 16'h1051, 16'hFFFF);
        rexp(ADDR_TRIG_CTRL, 16'h0400, 16'hFFFF);
        rexp(ADDR_CLKOUT_CTRL, 16'h0000, 16'hFFFF);
        rexp(5'h18, 16'h0000, 16'hFFFF);
        rexp(ADDR_STATUS, 16'h0000, 16'h000B);
        chk_pin("sample clock", 0, 1);
        chk_pin("trigger", 2, 0);
        wreg(ADDR_TRIG_CTRL, 16'h0407);
        chk_pin("trigger", 2, 3);
        // Serializer source: divider 2 times its four-cycle period
        wreg(ADDR_TRIG_CTRL, 16'h0201);
        chk_half("trigger half period", 2, 16'h0008);
        pll_s <= 1'h1;
        ref_s <= 1'h1;
        chk_pin("ref repeat", 1, 2);
        wreg(ADDR_PLL_CTRL, 16'h0001);
        chk_pin("ref repeat", 1, 0);
        chan_c_flag_pin <= 1'h1;
        wreg(ADDR_CLKOUT_CTRL, 16'h0030);
        chk_pin("chan c", 3, 4);
        wreg(ADDR_CLKOUT_CTRL, 16'h0034);
        chk_pin("chan d", 4, 0);
        wreg(ADDR_CLKOUT_CTRL, 16'h0031);
        chk_pin("chan c", 3, 2);
        wreg(ADDR_CLKOUT_CTRL, 16'h0010);
        cfg <= 2'h1;
        chk_pin("chan c", 3, 0);
        wreg(ADDR_CLKOUT_CTRL, 16'h0000);
        chk_pin("chan d", 4, 2);
        pwd <= 1'h1;
        chk_pin("chan c", 3, 0);
        pwd <= 1'h0;
        wreg(ADDR_PLL_CTRL, 16'h0007);
        wreg(ADDR_DIVIDERS, 16'h1051);
        rexp(ADDR_STATUS, 16'h000C, 16'h000F);
        wreg(ADDR_PLL_CTRL, 16'h0006);
        poll(16'h0001);
        rexp(ADDR_STATUS, 16'h0001, 16'h0003);
        poll(16'h0002);
        chk_half("sample half period", 0, 16'h0005);
        wreg(ADDR_SYSREF_CTRL, 16'h0003);
        rexp(ADDR_SYSREF_CTRL, 16'h0003, 16'hFFFF);
        // Capture follows the 64-cycle SYSREF half period of the source
        chk_half("sysref capture half period", 5, 16'h0040);
        wreg(ADDR_PLL_CTRL, 16'h0007);
        rexp(ADDR_STATUS, 16'h0000, 16'h0003);
        be <= 4'h1;
        wreg(ADDR_DIVIDERS, 16'hFF62);
        be <= 4'h3;
        rexp(ADDR_DIVIDERS, 16'h1062, 16'hFFFF);
        conclude();
    end
endmodule
`default_nettype wire
